/* logic/vbc_defines.vh */
// Constants for the oscillator band calibration engine.
// Included by vbc_calibration.v; holds definitions only.
`ifndef VBC_DEFINES_VH
`define VBC_DEFINES_VH

`define VBC_NUM_HI_W      10
`define VBC_NUM_LO_W      12
`define VBC_NUM_W         22
`define VBC_NUM_LO_MSB    11
`define VBC_CORE_W        2
`define VBC_BAND_W        8
`define VBC_BAND_MIN      8'h00
`define VBC_BAND_MAX      8'hff
`define VBC_CORE_LOWEST   2'h0
`define VBC_CORE_HIGHEST  2'h3
`define VBC_POLICY_LAST   1'b0
`define VBC_POLICY_SELECT 1'b1
`define VBC_MODE_INTERNAL 1'b0
`define VBC_MODE_EXTERNAL 1'b1
`define VBC_PUMP_NEGATIVE 1'b1
`define VBC_SETTLE_NS     100
`define VBC_CLK_NS        10

`endif

/* logic/vbc_calibration.v */
// Oscillator core and capacitor band calibration engine.
// Assumes configuration inputs are stable, synchronous to sys_clk_i,
// and that the comparator result arrives as an asynchronous level.
`timescale 1ns/1ns
`include "vbc_defines.vh"

module vbc_calibration #(
    parameter SETTLE_CYCLES = (`VBC_SETTLE_NS + `VBC_CLK_NS - 1) / `VBC_CLK_NS
) (
    input  wire                     sys_clk_i,
    input  wire                     rst_i,
    input  wire                     clk_en_i,
    input  wire                     freq_write_i,
    input  wire [`VBC_NUM_HI_W-1:0] num_hi_i,
    input  wire [`VBC_NUM_LO_W-1:0] num_lo_i,
    input  wire                     calibration_disable_i,
    input  wire [`VBC_CORE_W-1:0]   start_core_select_i,
    input  wire                     start_core_policy_i,
    input  wire [`VBC_BAND_W-1:0]   band_start_code_i,
    input  wire                     osc_mode_i,
    input  wire                     pump_polarity_i,
    input  wire                     freq_high_i,
    input  wire                     lock_i,
    output wire [`VBC_NUM_W-1:0]    frac_num_o,
    output wire [`VBC_CORE_W-1:0]   core_o,
    output wire [`VBC_BAND_W-1:0]   band_code_o,
    output wire                     busy_o,
    output wire                     done_o,
    output wire                     locked_o,
    output wire                     exhausted_o,
    output wire                     ext_osc_sel_o,
    output wire                     pump_polarity_o
);

    // How a search runs:
    // - an accepted write loads the starting core and band code
    //   and enters the settle state for SETTLE_CYCLES cycles;
    // - each step first looks at the synchronised lock level,
    //   then moves the band code one place toward the target;
    // - when the code reaches the end in its direction of travel,
    //   the neighbour core is tried once from the start code;
    // - a second end, or no neighbour core, ends the search as
    //   exhausted; a lock ends it as locked.
    // Only one core move is made per search, so a miss by more
    // than one core always ends exhausted.
    // The comparator and lock levels reach the sequencer two cycles
    // after a code change, so SETTLE_CYCLES below two would let a
    // step judge the previous code.
    // Writes during a search update the numerator only.

    // Sequencer states: idle, settle on a code, judge one step
    localparam ST_IDLE   = 2'h0;
    localparam ST_SETTLE = 2'h1;
    localparam ST_STEP   = 2'h2;
    // Settle counter width; SETTLE_CYCLES must stay below 256
    localparam CNT_W     = 8;

    // Unit steps and counter load, sized to the fields they feed
    localparam [CNT_W-1:0]       CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam [`VBC_BAND_W-1:0] BAND_ONE = {{(`VBC_BAND_W-1){1'b0}}, 1'b1};
    localparam [`VBC_CORE_W-1:0] CORE_ONE = {{(`VBC_CORE_W-1){1'b0}}, 1'b1};
    // Counter load, cut to the counter width on purpose
    localparam [CNT_W-1:0]       CNT_LOAD = SETTLE_CYCLES[CNT_W-1:0];

    // Stored numerator, search position and result flags
    reg [`VBC_NUM_W-1:0]  num_reg;
    reg [`VBC_CORE_W-1:0] core_reg;
    reg [`VBC_BAND_W-1:0] band_reg;
    reg [1:0]             state_reg;
    reg [CNT_W-1:0]       cnt_reg;
    reg                   moved_reg;
    reg                   done_reg;
    reg                   locked_reg;
    reg                   exh_reg;
    reg                   mode_reg;
    reg                   pol_reg;

    // First and second synchroniser stages
    reg                   hi_s1_reg;
    reg                   hi_s2_reg;
    reg                   lk_s1_reg;
    reg                   lk_s2_reg;

    // Next values, set by the combinational processes below
    reg [`VBC_NUM_W-1:0]  num_next;
    reg [`VBC_CORE_W-1:0] core_next;
    reg [`VBC_BAND_W-1:0] band_next;
    reg [1:0]             state_next;
    reg [CNT_W-1:0]       cnt_next;
    reg                   moved_next;
    reg                   done_next;
    reg                   locked_next;
    reg                   exh_next;

    // A write starts a search only for the internal oscillator
    wire start_req = freq_write_i && !calibration_disable_i &&
                     (osc_mode_i == `VBC_MODE_INTERNAL);

    // Starting core: selected field or the core used last time
    wire [`VBC_CORE_W-1:0] start_core =
        (start_core_policy_i == `VBC_POLICY_SELECT) ?
        start_core_select_i : core_reg;

    // Synchronised comparator: oscillator is above the target
    wire too_fast  = hi_s2_reg;
    wire lock_seen = lk_s2_reg;

    // End codes; an end only counts in the direction of travel,
    // so a start on code 0 or 255 still searches inward
    wire at_top    = (band_reg == `VBC_BAND_MAX);
    wire at_bottom = (band_reg == `VBC_BAND_MIN);
    wire at_end    = too_fast ? at_top : at_bottom;

    // Band step: larger code lowers the frequency
    wire [`VBC_BAND_W-1:0] band_step =
        too_fast ? band_reg + BAND_ONE
                 : band_reg - BAND_ONE;

    // Neighbour core: down when too fast, up when too slow
    wire can_up     = (core_reg != `VBC_CORE_HIGHEST);
    wire can_down   = (core_reg != `VBC_CORE_LOWEST);
    wire core_avail = too_fast ? can_down : can_up;
    wire [`VBC_CORE_W-1:0] core_step =
        too_fast ? core_reg - CORE_ONE
                 : core_reg + CORE_ONE;

    // Settle time is over when the counter reaches one; the step
    // state itself adds one more cycle
    wire settle_over = (cnt_reg <= CNT_ONE);

    // Two-flop synchroniser for the analog comparator level
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hi_s1_reg <= 1'b0;
            hi_s2_reg <= 1'b0;
        end else if (clk_en_i) begin
            hi_s1_reg <= freq_high_i;
            hi_s2_reg <= hi_s1_reg;
        end
    end

    // Two-flop synchroniser for the lock level
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lk_s1_reg <= 1'b0;
            lk_s2_reg <= 1'b0;
        end else if (clk_en_i) begin
            lk_s1_reg <= lock_i;
            lk_s2_reg <= lk_s1_reg;
        end
    end

    // Mode and pump polarity follow their inputs every enabled cycle
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg <= `VBC_MODE_INTERNAL;
            pol_reg  <= `VBC_PUMP_NEGATIVE;
        end else if (clk_en_i) begin
            mode_reg <= osc_mode_i;
            pol_reg  <= pump_polarity_i;
        end
    end

    // Numerator is taken on every write, even during a search;
    // the lower part fills bits 11..0
    always @* begin
        num_next = num_reg;
        if (freq_write_i) begin
            num_next = {num_hi_i, num_lo_i};
        end
    end

    // Numerator register
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            num_reg <= {`VBC_NUM_W{1'b0}};
        end else if (clk_en_i) begin
            num_reg <= num_next;
        end
    end

    // Search sequencer: next state, position, counter and flags
    always @* begin
        state_next  = state_reg;
        core_next   = core_reg;
        band_next   = band_reg;
        cnt_next    = cnt_reg;
        moved_next  = moved_reg;
        done_next   = done_reg;
        locked_next = locked_reg;
        exh_next    = exh_reg;
        case (state_reg)
            ST_IDLE: begin
                // Start a fresh search; old result flags clear here
                if (start_req) begin
                    core_next   = start_core;
                    band_next   = band_start_code_i;
                    moved_next  = 1'b0;
                    done_next   = 1'b0;
                    locked_next = 1'b0;
                    exh_next    = 1'b0;
                    cnt_next    = CNT_LOAD;
                    state_next  = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // Let the oscillator and comparator settle on a code
                if (settle_over) begin
                    state_next = ST_STEP;
                end else begin
                    cnt_next = cnt_reg - CNT_ONE;
                end
            end
            ST_STEP: begin
                cnt_next = CNT_LOAD;
                if (lock_seen) begin
                    // Locked: core and band stay as the final result
                    done_next   = 1'b1;
                    locked_next = 1'b1;
                    state_next  = ST_IDLE;
                end else if (!at_end) begin
                    // Not at the end yet: one band step
                    band_next  = band_step;
                    state_next = ST_SETTLE;
                end else if (!moved_reg && core_avail) begin
                    // Try the neighbour core once, from the start code
                    core_next  = core_step;
                    band_next  = band_start_code_i;
                    moved_next = 1'b1;
                    state_next = ST_SETTLE;
                end else begin
                    // No further core: stop as exhausted
                    done_next  = 1'b1;
                    exh_next   = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers; a low clock enable holds the search
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            core_reg   <= `VBC_CORE_LOWEST;
            band_reg   <= `VBC_BAND_MIN;
            state_reg  <= ST_IDLE;
            cnt_reg    <= {CNT_W{1'b0}};
            moved_reg  <= 1'b0;
            done_reg   <= 1'b0;
            locked_reg <= 1'b0;
            exh_reg    <= 1'b0;
        end else if (clk_en_i) begin
            core_reg   <= core_next;
            band_reg   <= band_next;
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            moved_reg  <= moved_next;
            done_reg   <= done_next;
            locked_reg <= locked_next;
            exh_reg    <= exh_next;
        end
    end

    // Numerator and search position
    assign frac_num_o      = num_reg;
    assign core_o          = core_reg;
    assign band_code_o     = band_reg;

    // Search status
    assign busy_o          = (state_reg != ST_IDLE);
    assign done_o          = done_reg;
    assign locked_o        = locked_reg;
    assign exhausted_o     = exh_reg;

    // Oscillator path settings
    assign ext_osc_sel_o   = mode_reg;
    assign pump_polarity_o = pol_reg;

endmodule

/* test/vbc_calibration_checker.sv */
// Port checker for the band calibration engine.
// Assumes clk_en_i high while the engine is watched.
`timescale 1ns/1ns
`include "vbc_defines.vh"
module vbc_calibration_checker (
    input wire sys_clk_i, rst_i, clk_en_i, freq_write_i,
    input wire [`VBC_NUM_HI_W-1:0] num_hi_i,
    input wire [`VBC_NUM_LO_W-1:0] num_lo_i,
    input wire calibration_disable_i, start_core_policy_i, osc_mode_i,
    input wire [`VBC_CORE_W-1:0] start_core_select_i, core_o,
    input wire [`VBC_BAND_W-1:0] band_start_code_i, band_code_o,
    input wire [`VBC_NUM_W-1:0] frac_num_o,
    input wire busy_o, done_o, locked_o, exhausted_o, ext_osc_sel_o
);
    // Accepted frequency write while idle
    wire take = clk_en_i && freq_write_i && !busy_o;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    chk_num_join: assert property (
        clk_en_i && freq_write_i |=> frac_num_o == $past({num_hi_i, num_lo_i}))
        else $error("numerator wrong");
    chk_write_starts: assert property (
        take && !calibration_disable_i && !osc_mode_i |=> busy_o)
        else $error("no start");
    chk_write_held: assert property (
        take && (calibration_disable_i || osc_mode_i) |=> !busy_o)
        else $error("bad start");
    chk_sel_core: assert property (
        $rose(busy_o) && start_core_policy_i |->
        core_o == $past(start_core_select_i)) else $error("start core");
    chk_last_core: assert property (
        $rose(busy_o) && !start_core_policy_i |-> core_o == $past(core_o))
        else $error("last core");
    chk_band_start: assert property (
        $rose(busy_o) |-> band_code_o == $past(band_start_code_i))
        else $error("start band");
    chk_one_step: assert property (
        busy_o && $past(busy_o) && $stable(core_o) && !$stable(band_code_o)
        |-> band_code_o - $past(band_code_o) == 8'h01 ||
        $past(band_code_o) - band_code_o == 8'h01) else $error("band jump");
    chk_end_flags: assert property (
        $fell(busy_o) |-> done_o && (locked_o ^ exhausted_o))
        else $error("end flags");
    chk_idle_hold: assert property (
        !busy_o |=> busy_o || ($stable(core_o) && $stable(band_code_o)))
        else $error("result moved");
    chk_ext_copy: assert property (
        clk_en_i |=> ext_osc_sel_o == $past(osc_mode_i)) else $error("mode");
    cover property ($fell(busy_o) && locked_o);
    cover property ($fell(busy_o) && exhausted_o);
    cover property ($rose(busy_o) && !start_core_policy_i);
endmodule
bind vbc_calibration vbc_calibration_checker chk (.*);

/* test/vbc_osc_model.sv */
// Oscillator comparator model: frequency too high, and lock.
// Assumes the bench sets one target core and band per run.
`timescale 1ns/1ns
module vbc_osc_model (
    input  wire [1:0] core_i,
    input  wire [7:0] band_i,
    input  wire [1:0] tcore_i,
    input  wire [7:0] tband_i,
    output wire       freq_high_o,
    output wire       lock_o
);
    // Higher core or smaller band code raises the frequency
    assign freq_high_o = (core_i > tcore_i) ||
        (core_i == tcore_i && band_i < tband_i);
    // Lock only on the target core and band
    assign lock_o = (core_i == tcore_i) && (band_i == tband_i);
endmodule

/* test/vbc_calibration_bench.sv */
// Self-checking bench for the band calibration engine.
// Assumes the oscillator model answers as a plain level.
`timescale 1ns/1ns
module vbc_calibration_bench;
    reg clk = 0, rst = 1, wr = 0, dis = 0, pol = 1, mode = 0, pp = 0, ce = 1;
    reg [9:0] hi = 0;
    reg [11:0] lo = 0;
    reg [1:0] sel = 0, tc = 0;
    reg [7:0] sb = 0, tb = 0;
    wire [21:0] num;
    wire [1:0] core;
    wire [7:0] band;
    wire fh, lk, busy, done, lkd, exh, ext, ppo;
    integer bad_count = 0, total_checks = 0, cyc = 0;
    vbc_calibration #(.SETTLE_CYCLES(2)) dut (.sys_clk_i(clk), .rst_i(rst),
        .clk_en_i(ce), .freq_write_i(wr), .num_hi_i(hi), .num_lo_i(lo),
        .calibration_disable_i(dis), .start_core_select_i(sel),
        .start_core_policy_i(pol), .band_start_code_i(sb), .osc_mode_i(mode),
        .pump_polarity_i(pp), .freq_high_i(fh), .lock_i(lk), .frac_num_o(num),
        .core_o(core), .band_code_o(band), .busy_o(busy), .done_o(done),
        .locked_o(lkd), .exhausted_o(exh), .ext_osc_sel_o(ext),
        .pump_polarity_o(ppo));
    vbc_osc_model osc (.core_i(core), .band_i(band), .tcore_i(tc),
        .tband_i(tb), .freq_high_o(fh), .lock_o(lk));
    initial forever #5 clk = ~clk;
    task test_done;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Program start point and target, write, wait for the end
    task cal(input [1:0] s, input p, input [7:0] b, input [1:0] c,
             input [7:0] t);
        @(posedge clk) {sel, pol, sb, tc, tb, wr} <= {s, p, b, c, t, 1'b1};
        @(posedge clk) wr <= 0;
        #1 cmp(busy, 1);
        while (busy === 1'b1) @(posedge clk) #1;
    endtask
    task res(input [1:0] c, input [7:0] b, input l);
        cmp(core, c);
        cmp(band, b);
        cmp({done, lkd, exh}, {1'b1, l, !l});
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            test_done;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        #1 cmp(ppo, 1);
        @(posedge clk) {dis, hi, lo, wr} <= {1'b1, 10'h001, 12'h000, 1'b1};
        @(posedge clk) {dis, wr} <= 2'b10;
        #1 cmp(num, 22'h001000);
        cmp(busy, 0);
        @(posedge clk) dis <= 0;
        cal(2'h2, 1, 8'h10, 2'h2, 8'h14); res(2'h2, 8'h14, 1);
        cal(2'h1, 1, 8'h30, 2'h1, 8'h2c); res(2'h1, 8'h2c, 1);
        cal(2'h0, 1, 8'h08, 2'h1, 8'h0a); res(2'h1, 8'h0a, 1);
        cal(2'h3, 1, 8'hf0, 2'h0, 8'h00); res(2'h2, 8'hff, 0);
        cal(2'h0, 0, 8'h40, 2'h2, 8'h42); res(2'h2, 8'h42, 1);
        cal(2'h1, 1, 8'h00, 2'h1, 8'h03); res(2'h1, 8'h03, 1);
        @(posedge clk) {ce, hi, wr} <= {1'b0, 10'h3ff, 1'b1};
        @(posedge clk) wr <= 0;
        #1 cmp({busy, num}, {1'b0, 22'h001000});
        @(posedge clk) ce <= 1;
        @(posedge clk) {mode, pp, wr} <= 3'b101;
        @(posedge clk) wr <= 0;
        #1 cmp({busy, ext, ppo}, 3'b010);
        test_done;
    end
endmodule
